// File: hw/aio_bus.sv
`timescale 1ns/1ns
module aio_bus #(
   parameter int ADDR_W = aio_pkg::ADDR_W,
   parameter int DATA_W = aio_pkg::DATA_W,
   parameter int N_STROBE = aio_pkg::N_STROBE,
   parameter int SEL_W = aio_pkg::SEL_W
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Configuration
   input wire logic aux_bus_en,
   input wire logic [N_STROBE-1:0] strobe_en,
   // I/O instruction port
   input wire logic io_req,
   input wire logic io_cycle,
   input wire logic io_write,
   input wire logic io_shadow,
   input wire logic [SEL_W-1:0] io_sel,
   input wire logic [ADDR_W-1:0] io_addr,
   input wire logic [DATA_W-1:0] io_wdata,
   output logic io_ready,
   output logic io_done,
   output logic io_err,
   output logic [DATA_W-1:0] io_rdata,
   output logic irq_block,
   // Shadow read port
   input wire logic [SEL_W+ADDR_W-1:0] shadow_raddr,
   output logic [DATA_W-1:0] shadow_rdata,
   // General-purpose use of the shared pins
   input wire logic [DATA_W-1:0] gp_pa_out,
   input wire logic [DATA_W-1:0] gp_pa_oe,
   input wire logic [ADDR_W-1:0] gp_pb_out,
   input wire logic [ADDR_W-1:0] gp_pb_oe,
   input wire logic [N_STROBE-1:0] gp_pe_out,
   input wire logic [N_STROBE-1:0] gp_pe_oe,
   output logic [DATA_W-1:0] gp_pa_in,
   output logic [ADDR_W-1:0] gp_pb_in,
   // First port pins, data lines
   input wire logic [DATA_W-1:0] pa_in,
   output logic [DATA_W-1:0] pa_out,
   output logic [DATA_W-1:0] pa_oe,
   // Second port pins, aux_address_pins
   input wire logic [ADDR_W-1:0] aux_address_pins_in,
   output logic [ADDR_W-1:0] aux_address_pins_out,
   output logic [ADDR_W-1:0] aux_address_pins_oe,
   // Fifth port pins, strobes (active low when enabled)
   output logic [N_STROBE-1:0] pe_out,
   output logic [N_STROBE-1:0] pe_oe
);

   // ------------------------------------------------------------
   // Elaboration checks
   // ------------------------------------------------------------
   if (ADDR_W != aio_pkg::ADDR_W || DATA_W != aio_pkg::DATA_W)
   begin : g_bad_width
      $error("aio_bus: bus widths are fixed by the pin map");
   end
   if ((1 << SEL_W) < N_STROBE)
   begin : g_bad_sel
      $error("aio_bus: strobe select too narrow");
   end

   aio_pkg::aio_state_t state;
   aio_pkg::aio_state_t next_state;
   logic [aio_pkg::CNT_W-1:0] cnt;
   logic write_op;
   logic shadow_op;
   logic [SEL_W-1:0] sel;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic take;
   logic refuse;
   logic last_cyc;
   logic [N_STROBE-1:0] next_pe_out;
   logic [N_STROBE-1:0] next_pe_oe;
   logic [DATA_W-1:0] next_pa_out;
   logic [DATA_W-1:0] next_pa_oe;

   function automatic logic [aio_pkg::CNT_W-1:0] phase_len(
      input aio_pkg::aio_state_t st);
      case (st)
         aio_pkg::AIO_SETUP: phase_len = aio_pkg::CNT_W'(aio_pkg::SETUP_CYC);
         aio_pkg::AIO_STROBE: phase_len = aio_pkg::CNT_W'(aio_pkg::STROBE_CYC);
         aio_pkg::AIO_HOLD: phase_len = aio_pkg::CNT_W'(aio_pkg::HOLD_CYC);
         default: phase_len = aio_pkg::CNT_ONE;
      endcase
   endfunction

   // ------------------------------------------------------------
   // Request acceptance
   // ------------------------------------------------------------
   assign io_ready = (state == aio_pkg::AIO_IDLE);
   assign take = io_ready && io_req && io_cycle && aux_bus_en &&
                 strobe_en[io_sel];
   // A request with the bus off or its strobe disabled ends at once.
   assign refuse = io_ready && io_req && io_cycle && !take;
   assign last_cyc = (cnt == aio_pkg::CNT_ONE);

   // ------------------------------------------------------------
   // Transfer sequencer
   // ------------------------------------------------------------
   always_comb
   begin
      next_state = state;
      case (state)
         aio_pkg::AIO_IDLE:
            if (take)
            begin
               next_state = aio_pkg::AIO_SETUP;
            end
         aio_pkg::AIO_SETUP:
            if (last_cyc)
            begin
               next_state = aio_pkg::AIO_STROBE;
            end
         aio_pkg::AIO_STROBE:
            if (last_cyc)
            begin
               next_state = aio_pkg::AIO_HOLD;
            end
         aio_pkg::AIO_HOLD:
            if (last_cyc)
            begin
               next_state = aio_pkg::AIO_IDLE;
            end
         default: next_state = aio_pkg::AIO_IDLE;
      endcase
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         state <= aio_pkg::AIO_IDLE;
         cnt <= aio_pkg::CNT_ZERO;
      end
      else
      begin
         state <= next_state;
         if (next_state != state)
         begin
            cnt <= phase_len(next_state);
         end
         else if (cnt != aio_pkg::CNT_ZERO)
         begin
            cnt <= cnt - aio_pkg::CNT_ONE;
         end
      end
   end

   // ------------------------------------------------------------
   // Captured request
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         write_op <= 1'b0;
         shadow_op <= 1'b0;
         sel <= '0;
         addr <= '0;
         wdata <= '0;
      end
      else if (take)
      begin
         write_op <= io_write;
         shadow_op <= io_shadow && io_write;
         sel <= io_sel;
         addr <= io_addr;
         wdata <= io_wdata;
      end
   end

   // ------------------------------------------------------------
   // Answer to the instruction port
   // ------------------------------------------------------------
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         io_done <= 1'b0;
         io_err <= 1'b0;
         io_rdata <= '0;
      end
      else
      begin
         io_done <= refuse ||
                    (state == aio_pkg::AIO_HOLD && last_cyc);
         io_err <= refuse;
         if (state == aio_pkg::AIO_STROBE && last_cyc && !write_op)
         begin
            io_rdata <= pa_in;
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt hold-off
   // ------------------------------------------------------------
   // block interrupts
   // Held from acceptance of a shadowed write until the hold phase ends,
   // a cycle after the shadow is written, so the two never differ unseen.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         irq_block <= 1'b0;
      end
      else if (take && io_write && io_shadow)
      begin
         irq_block <= 1'b1;
      end
      else if (state == aio_pkg::AIO_HOLD && last_cyc)
      begin
         irq_block <= 1'b0;
      end
   end

   // ------------------------------------------------------------
   // Shadow copy
   // ------------------------------------------------------------
   // shadow every write made with io_shadow set
   aio_shadow_mem #(
      .AW(SEL_W + ADDR_W),
      .DW(DATA_W)
   ) u_shadow (
      .clk_sys(clk_sys),
      .arst_n(arst_n),
      .we(shadow_op && state == aio_pkg::AIO_STROBE && last_cyc),
      .waddr({sel, addr}),
      .wdata(wdata),
      .raddr(shadow_raddr),
      .rdata(shadow_rdata)
   );

   // ------------------------------------------------------------
   // Shared pin multiplexing
   // ------------------------------------------------------------
   always_comb
   begin
      for (int i = 0; i < N_STROBE; i++)
      begin
         if (aux_bus_en && strobe_en[i])
         begin
            next_pe_oe[i] = 1'b1;
            next_pe_out[i] = !(state == aio_pkg::AIO_STROBE &&
                               sel == SEL_W'(i));
         end
         else
         begin
            next_pe_oe[i] = gp_pe_oe[i];
            next_pe_out[i] = gp_pe_out[i];
         end
      end
      if (aux_bus_en)
      begin
         next_pa_out = wdata;
         next_pa_oe = {DATA_W{write_op && state != aio_pkg::AIO_IDLE}};
      end
      else
      begin
         next_pa_out = gp_pa_out;
         next_pa_oe = gp_pa_oe;
      end
   end

   // Pin drivers are registered, so every pin moves one cycle after
   // the sequencer; address, data and strobe keep their alignment.
   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         pa_out <= '0;
         pa_oe <= '0;
         aux_address_pins_out <= '0;
         aux_address_pins_oe <= '0;
         pe_out <= '0;
         pe_oe <= '0;
      end
      else
      begin
         pa_out <= next_pa_out;
         pa_oe <= next_pa_oe;
         pe_out <= next_pe_out;
         pe_oe <= next_pe_oe;
         if (aux_bus_en)
         begin
            aux_address_pins_out <= addr;
            aux_address_pins_oe <= {ADDR_W{1'b1}};
         end
         else
         begin
            aux_address_pins_out <= gp_pb_out;
            aux_address_pins_oe <= gp_pb_oe;
         end
      end
   end

   assign gp_pa_in = pa_in;
   assign gp_pb_in = aux_address_pins_in;

endmodule // aio_bus

// File: hw/aio_pkg.sv
package aio_pkg;

   // ------------------------------------------------------------
   // Bus geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 6;
   localparam int DATA_W = 8;
   localparam int N_STROBE = 8;
   localparam int SEL_W = 3;
   localparam int SPACE_SIZE = 64;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 10;
   localparam int T_SETUP_NS = 10;
   localparam int T_STROBE_NS = 30;
   localparam int T_HOLD_NS = 10;
   localparam int SETUP_CYC = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int STROBE_CYC =
      (T_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int HOLD_CYC = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int CNT_W = 4;
   localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
   localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;

   // ------------------------------------------------------------
   // Transfer sequencer
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      AIO_IDLE = 2'b00,
      AIO_SETUP = 2'b01,
      AIO_STROBE = 2'b10,
      AIO_HOLD = 2'b11
   } aio_state_t;

endpackage

// File: hw/aio_shadow_mem.sv
`timescale 1ns/1ns
module aio_shadow_mem #(
   parameter int AW = 9,
   parameter int DW = 8
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Write port
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [DW-1:0] wdata,
   // Read port
   input wire logic [AW-1:0] raddr,
   output logic [DW-1:0] rdata
);

   logic [DW-1:0] mem [0:(1<<AW)-1];

   // ------------------------------------------------------------
   // Storage
   // ------------------------------------------------------------
   // The array itself has no reset; software must write a shadow
   // before trusting a read of it.
   always_ff @(posedge clk_sys)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   always_ff @(posedge clk_sys or negedge arst_n)
   begin
      if (!arst_n)
      begin
         rdata <= '0;
      end
      else
      begin
         rdata <= mem[raddr];
      end
   end

endmodule // aio_shadow_mem

// File: test/aio_bus_properties.sv
`timescale 1ns/1ns
module aio_bus_properties (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic arst_n,
   // Watched ports
   input wire logic aux_bus_en,
   input wire logic [7:0] strobe_en,
   input wire logic io_req,
   input wire logic io_cycle,
   input wire logic io_write,
   input wire logic io_shadow,
   input wire logic [2:0] io_sel,
   input wire logic io_ready,
   input wire logic io_done,
   input wire logic io_err,
   input wire logic irq_block,
   input wire logic [7:0] pa_oe,
   input wire logic [7:0] pe_out,
   input wire logic [5:0] gp_pb_oe,
   input wire logic [5:0] aux_address_pins_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!arst_n);
   logic req;
   logic take;
   assign req = io_ready & io_req & io_cycle;
   assign take = req & aux_bus_en & strobe_en[io_sel];

   property p_off_err;
      req && !aux_bus_en |=> io_done && io_err;
   endproperty
   a_off_err: assert property (p_off_err)
      else $error("disabled bus did not refuse");
   property p_sel_err;
      req && aux_bus_en && !strobe_en[io_sel] |=> io_done && io_err;
   endproperty
   a_sel_err: assert property (p_sel_err)
      else $error("disabled strobe did not refuse");
   property p_mem;
      io_ready && io_req && !io_cycle |=> !io_done;
   endproperty
   a_mem: assert property (p_mem)
      else $error("memory cycle reached the bus");
   property p_done;
      take |-> ##6 io_done && !io_err;
   endproperty
   a_done: assert property (p_done)
      else $error("transfer end late or flagged");
   property p_strobe;
      take && io_sel == 3'h0 |-> ##2 pe_out[0] ##1 (!pe_out[0]) [*3]
         ##1 pe_out[0];
   endproperty
   a_strobe: assert property (p_strobe)
      else $error("strobe pulse shape wrong");
   property p_wr_drive;
      take && io_write |-> ##3 (pa_oe == 8'hff) [*4];
   endproperty
   a_wr_drive: assert property (p_wr_drive)
      else $error("write data not driven");
   property p_irq;
      take && io_write && io_shadow |=> irq_block [*5];
   endproperty
   a_irq: assert property (p_irq)
      else $error("interrupt hold dropped early");
   property p_gp;
      !aux_bus_en |=> aux_address_pins_oe == $past(gp_pb_oe);
   endproperty
   a_gp: assert property (p_gp)
      else $error("address pins not general lines");
endmodule // aio_bus_properties

bind aio_bus aio_bus_properties aio_bus_properties_i (.clk_sys, .arst_n,
   .aux_bus_en, .strobe_en, .io_req, .io_cycle, .io_write, .io_shadow,
   .io_sel, .io_ready, .io_done, .io_err, .irq_block, .pa_oe, .pe_out,
   .gp_pb_oe, .aux_address_pins_oe);

// File: test/aio_ext_regs.sv
`timescale 1ns/1ns
module aio_ext_regs (
   // Clock
   input wire logic clk_sys,
   // Board side of the pins
   input wire logic [7:0] pa_out,
   input wire logic [7:0] pa_oe,
   input wire logic [5:0] addr,
   input wire logic [7:0] pe_out,
   input wire logic [7:0] pe_oe,
   output logic [7:0] pa_in
);
   logic [7:0] mem [9][64];
   logic [7:0] act, prev, rd;
   // An idle line shows a changing value, so a stale read cannot pass.
   logic [7:0] last = 8'h5a;
   // Strobe 7 has a page register; page bit 0 selects a ninth bank.
   localparam logic [5:0] PAGE_A = 6'h20;
   // A strobe 0 write to the kick address only counts pulses; nothing is stored.
   localparam logic [5:0] KICK_A = 6'h3e;
   logic [7:0] page = 8'h00;
   logic [7:0] kicks = 8'h00;

   always_comb
   begin
      act = pe_oe & ~pe_out;
      rd = ~last;
      for (int i = 0; i < 8; i++)
      begin
         if (act[i] && pa_oe == 8'h00)
            rd = mem[(i == 7 && page[0]) ? 8 : i][addr];
      end
      pa_in = (pa_out & pa_oe) | (rd & ~pa_oe);
   end

   always @(posedge clk_sys)
   begin
      last <= pa_in;
      prev <= act;
      for (int i = 0; i < 8; i++)
      begin
         if (prev[i] && !act[i] && pa_oe == 8'hff)
         begin
            if (i == 0 && addr == KICK_A)
               kicks <= kicks + 8'h01;
            else if (i == 7 && addr == PAGE_A)
               page <= pa_out;
            else
               mem[(i == 7 && page[0]) ? 8 : i][addr] <= pa_out;
         end
      end
   end
endmodule // aio_ext_regs

// File: test/testbench.sv
`timescale 1ns/1ns
module testbench;
   logic clk_sys, arst_n, aux_bus_en, io_req, io_cycle, io_write;
   logic io_shadow, io_ready, io_done, io_err, irq_block;
   logic [7:0] strobe_en, io_wdata, io_rdata, shadow_rdata, gp_pa_out;
   logic [7:0] gp_pa_oe, gp_pe_out, gp_pe_oe, gp_pa_in, pa_in, pa_out;
   logic [7:0] pa_oe, pe_out, pe_oe;
   logic [5:0] io_addr, gp_pb_out, gp_pb_oe, gp_pb_in;
   logic [5:0] aux_address_pins_in, aux_address_pins_out;
   logic [5:0] aux_address_pins_oe;
   logic [2:0] io_sel;
   logic [8:0] shadow_raddr;
   int err_total, checks;
   logic blk_seen;

   // Address lines carry board pull-ups.
   assign aux_address_pins_in = (aux_address_pins_out & aux_address_pins_oe)
      | ~aux_address_pins_oe;

   aio_bus aio_bus_i (.clk_sys, .arst_n, .aux_bus_en, .strobe_en, .io_req,
      .io_cycle, .io_write, .io_shadow, .io_sel, .io_addr, .io_wdata,
      .io_ready, .io_done, .io_err, .io_rdata, .irq_block, .shadow_raddr,
      .shadow_rdata, .gp_pa_out, .gp_pa_oe, .gp_pb_out, .gp_pb_oe,
      .gp_pe_out, .gp_pe_oe, .gp_pa_in, .gp_pb_in, .pa_in, .pa_out, .pa_oe,
      .aux_address_pins_in, .aux_address_pins_out, .aux_address_pins_oe,
      .pe_out, .pe_oe);
   aio_ext_regs aio_ext_regs_i (.clk_sys, .pa_out, .pa_oe,
      .addr(aux_address_pins_out), .pe_out, .pe_oe, .pa_in);

   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end

   // ----
   // Tasks
   // ----
   task automatic test_done;
      if (err_total == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string name, input logic [8:0] exp, got);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("mismatch %s exp %h got %h", name, exp, got);
      end
   endtask

   task automatic io_op(input logic wr, input logic [2:0] sel,
      input logic [5:0] a, input logic [7:0] d);
      int n;
      blk_seen = 1'b0;
      io_write = wr;
      io_sel = sel;
      io_addr = a;
      io_wdata = d;
      io_req = 1'b1;
      @(posedge clk_sys);
      #1 io_req = 1'b0;
      n = 0;
      while (io_done !== 1'b1 && n < 20)
      begin
         @(posedge clk_sys);
         #1 n++;
         blk_seen = blk_seen | irq_block;
      end
      if (n == 20)
      begin
         err_total++;
         test_done();
      end
   endtask

   task automatic t_rw;
      logic [7:0] d;
      for (int p = 0; p < 2; p++)
         for (int k = 0; k < 4; k++)
         begin
            d = {k[1:0], 6'h2a} ^ 8'h13;
            io_op(p == 0, {3{k[1]}}, {6{k[0]}}, d);
            chk("io_err", 9'h0, io_err);
            chk("irq_block", p == 0 ? 9'h1 : 9'h0, blk_seen);
            if (p == 1)
            begin
               chk("io_rdata", d, io_rdata);
               shadow_raddr = {{3{k[1]}}, {6{k[0]}}};
               @(posedge clk_sys);
               #1 chk("shadow", d, shadow_rdata);
            end
         end
      chk("addr_oe", 9'h3f, aux_address_pins_oe);
   endtask

   task automatic t_refuse;
      logic seen;
      seen = 1'b0;
      io_cycle = 1'b0;
      io_req = 1'b1;
      repeat (10)
      begin
         @(posedge clk_sys);
         #1 seen = seen | io_done;
      end
      io_req = 1'b0;
      io_cycle = 1'b1;
      @(posedge clk_sys);
      #1 chk("mem_done", 9'h0, seen);
      io_op(1'b0, 3'h1, 6'h05, 8'h00);
      chk("sel_err", 9'h1, io_err);
      @(posedge clk_sys);
      #1 aux_bus_en = 1'b0;
      io_op(1'b1, 3'h0, 6'h05, 8'h00);
      chk("off_err", 9'h1, io_err);
   endtask

   task automatic t_gp;
      gp_pb_out = 6'h2a;
      gp_pb_oe = 6'h0f;
      gp_pa_out = 8'h96;
      gp_pa_oe = 8'hff;
      gp_pe_out = 8'h02;
      gp_pe_oe = 8'h02;
      repeat (2) @(posedge clk_sys);
      #1 chk("gp_oe", 9'h0f, aux_address_pins_oe);
      chk("gp_in", 9'h3a, gp_pb_in);
      chk("pa_oe", 9'hff, pa_oe);
      chk("gp_pa_in", 9'h96, gp_pa_in);
      chk("pe_oe", 9'h02, pe_oe);
      aux_bus_en = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 chk("bus_oe", 9'h3f, aux_address_pins_oe);
      chk("pa_oe", 9'h00, pa_oe);
      chk("pe_oe", 9'h83, pe_oe);
   endtask

   task automatic t_page;
      io_op(1'b1, 3'h7, 6'h20, 8'h01);
      io_op(1'b1, 3'h7, 6'h05, 8'hc3);
      io_op(1'b1, 3'h7, 6'h20, 8'h00);
      io_op(1'b1, 3'h7, 6'h05, 8'h3c);
      io_op(1'b0, 3'h7, 6'h05, 8'h00);
      chk("page0", 9'h3c, io_rdata);
      io_op(1'b1, 3'h7, 6'h20, 8'h01);
      io_op(1'b0, 3'h7, 6'h05, 8'h00);
      chk("page1", 9'hc3, io_rdata);
   endtask

   task automatic t_kick;
      io_op(1'b1, 3'h0, 6'h3e, 8'h01);
      chk("irq_block", 9'h1, blk_seen);
      io_shadow = 1'b0;
      io_op(1'b1, 3'h0, 6'h3e, 8'h02);
      chk("irq_block", 9'h0, blk_seen);
      io_shadow = 1'b1;
      shadow_raddr = {3'h0, 6'h3e};
      @(posedge clk_sys);
      #1 chk("shadow", 9'h01, shadow_rdata);
      chk("kicks", 9'h02, aio_ext_regs_i.kicks);
   endtask

   // ----
   // Sequence
   // ----
   initial
   begin
      err_total = 0;
      checks = 0;
      arst_n = 1'b0;
      aux_bus_en = 1'b1;
      strobe_en = 8'h81;
      {io_req, io_write, io_sel, io_addr, io_wdata} = '0;
      io_cycle = 1'b1;
      io_shadow = 1'b1;
      {shadow_raddr, gp_pa_out, gp_pa_oe, gp_pe_out, gp_pe_oe} = '0;
      {gp_pb_out, gp_pb_oe} = '0;
      repeat (20) @(posedge clk_sys);
      #1 arst_n = 1'b1;
      @(posedge clk_sys);
      #1 t_rw();
      t_page();
      t_kick();
      t_refuse();
      t_gp();
      test_done();
   end
endmodule // testbench
